// ===== design/bit6_mux.sv
// channel 0 shared input bit 6 multiplexer with capture fifo
// How it works
// - config picks add bus, hdlc or payload role
// - add bus bit 6 latched on falling edge
// - hdlc mode uses pin as byte bit 6
// - device drives its own hdlc byte clock
// - hdlc bit sampled at byte clock rise
// - payload bit sampled on input clock rise
// - frame end pulses one period, last bit
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// first-word-fall-through fifo, full and empty from pointer compare
module bit6_fifo #(
	parameter int W     = 3,
	parameter int DEPTH = 32
) (
	input  wire logic         i_clk,   // system clock
	input  wire logic         i_rst_n, // sync reset, active low
	input  wire logic         i_valid, // write request
	output logic              o_ready, // not full
	input  wire logic [W-1:0] i_data,  // write word
	output logic              o_valid, // not empty
	input  wire logic         i_ready, // consumer takes word
	output logic [W-1:0]      o_data   // head word
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} ptr_type;

	ptr_type    ptr_reg;
	ptr_type    ptr_next;
	logic [W-1:0] mem [DEPTH];
	logic       do_wr;
	logic       do_rd;

	// extra pointer bit tells full from empty
	assign o_ready = !((ptr_reg.wr[AW] != ptr_reg.rd[AW]) &&
		(ptr_reg.wr[AW-1:0] == ptr_reg.rd[AW-1:0]));
	assign o_valid = (ptr_reg.wr != ptr_reg.rd);
	assign o_data  = mem[ptr_reg.rd[AW-1:0]];
	assign do_wr   = i_valid && o_ready;
	assign do_rd   = i_ready && o_valid;

	// pointer advance
	always_comb begin
		ptr_next = ptr_reg;
		if (do_wr) begin
			ptr_next.wr = ptr_reg.wr + 1'b1;
		end
		if (do_rd) begin
			ptr_next.rd = ptr_reg.rd + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ptr_reg <= '0;
		end else begin
			ptr_reg <= ptr_next;
		end
		if (do_wr) begin
			mem[ptr_reg.wr[AW-1:0]] <= i_data;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
// top: routes the shared pin by configuration
module bit6_mux
	import bit6_mux_pkg::*;
#(
	parameter logic [DIV_W-1:0] HDLC_HALF  = DIV_W'(HDLC_HALF_DEF),
	parameter logic [CNT_W-1:0] FRAME_BITS = CNT_W'(FRAME_BITS_DEF),
	parameter int               FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input  wire logic         i_clk,                 // system clock
	input  wire logic         i_rst_n,               // sync reset, low
	input  wire logic         i_add_bus_enable,      // add bus role on
	input  wire bit6_mux_pkg::mode_type i_mode,      // mode, bus off
	input  wire logic         i_add_bus_clock,       // add bus clock
	input  wire logic         i_payload_input_clock, // payload clock
	input  wire logic         i_shared_bit6,         // the shared pin
	input  wire logic         i_overhead_slot,       // framer overhead
	output logic              o_hdlc_tx_byte_clock,  // byte clock out
	output logic              o_overhead_skip_indicator, // skip next
	output logic              o_frame_end_pulse,     // last frame bit
	output bit6_mux_pkg::sample_type o_sample,       // captured bit
	output logic              o_sample_valid,        // sample ready
	input  wire logic         i_sample_ready,        // consumer takes
	output logic              o_overflow             // sample dropped
);
	import bit6_mux_pkg::*;

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HDLC_HALF - 1);
	localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);

	core_type core_reg;
	core_type core_next;
	add_type  add_reg;
	add_type  add_next;
	pay_type  pay_reg;
	pay_type  pay_next;
	logic     hdlc_on;
	logic     clear_on;
	logic     idle_on;
	logic     add_edge;
	logic     pay_edge;
	logic     hclk_rise;
	logic     f_ready;

	// decoded configuration, all in the system domain
	assign hdlc_on  = !i_add_bus_enable && (i_mode == MODE_HDLC);
	assign clear_on = !i_add_bus_enable && (i_mode == MODE_CLEAR);
	assign idle_on  = !i_add_bus_enable && !hdlc_on && !clear_on;
	// toggles arrive after two stages, stage 2 vs 3 gives the event
	assign add_edge  = core_reg.add_t[1] ^ core_reg.add_t[2];
	assign pay_edge  = core_reg.pay_t[1] ^ core_reg.pay_t[2];
	assign hclk_rise = hdlc_on && (core_reg.div == DIV_LAST) &&
		!core_reg.hclk;

	////////////////////////////////////////////////////////////////////
	// system domain: byte clock divider, crossings, capture
	always_comb begin
		core_next         = core_reg;
		core_next.cfg_add = i_add_bus_enable;
		core_next.cfg_clr = clear_on;
		core_next.add_t   = {core_reg.add_t[1:0], add_reg.tog};
		core_next.pay_t   = {core_reg.pay_t[1:0], pay_reg.tog};
		core_next.pin_s   = {core_reg.pin_s[0], i_shared_bit6};
		core_next.push    = 1'b0;
		core_next.ovf     = 1'b0;
		// byte clock only runs in hdlc mode
		if (hdlc_on) begin
			if (core_reg.div == DIV_LAST) begin
				core_next.div  = '0;
				core_next.hclk = !core_reg.hclk;
			end else begin
				core_next.div = core_reg.div + 1'b1;
			end
		end else begin
			core_next.div  = '0;
			core_next.hclk = 1'b0;
		end
		// role choice; idle mode takes nothing
		if (i_add_bus_enable && add_edge) begin
			core_next.smp.role = ROLE_ADD;
			core_next.smp.bit6 = add_reg.bit6;
			core_next.push     = f_ready;
			core_next.ovf      = !f_ready;
		end else if (hclk_rise) begin
			// synced pin was settled while the byte clock was low
			core_next.smp.role = ROLE_HDLC;
			core_next.smp.bit6 = core_reg.pin_s[1];
			core_next.push     = f_ready;
			core_next.ovf      = !f_ready;
		end else if (clear_on && pay_edge) begin
			// link data is stable for a whole link period here
			core_next.smp.role = ROLE_PAYLOAD;
			core_next.smp.bit6 = pay_reg.bit6;
			core_next.push     = f_ready;
			core_next.ovf      = !f_ready;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			core_reg          <= '0;
			core_reg.smp.role <= ROLE_ADD;
		end else begin
			core_reg <= core_next;
		end
	end

	a_role_select: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		core_reg.push |-> ((core_reg.smp.role == ROLE_ADD) ==
		$past(i_add_bus_enable)))
		else $error("sample role disagrees with add bus enable");
	a_idle_ignore: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		idle_on |=> !core_reg.push)
		else $error("pin captured with no role selected");
	a_hdlc_role: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		core_reg.push && (core_reg.smp.role == ROLE_HDLC) |->
		$past(hdlc_on) && $rose(core_reg.hclk))
		else $error("hdlc sample outside a byte clock rise");
	a_hclk_off: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		!hdlc_on |=> !o_hdlc_tx_byte_clock)
		else $error("byte clock runs outside hdlc mode");
	a_hclk_half: assert property (@(posedge i_clk)
		disable iff (!i_rst_n || !hdlc_on)
		$rose(o_hdlc_tx_byte_clock) |->
		o_hdlc_tx_byte_clock[*4] ##1 !o_hdlc_tx_byte_clock)
		else $error("byte clock high phase wrong length");
	a_hdlc_capture: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		$rose(o_hdlc_tx_byte_clock) && $past(hdlc_on) |->
		(core_reg.push || core_reg.ovf) &&
		(core_reg.smp.bit6 == $past(core_reg.pin_s[1])))
		else $error("hdlc bit not taken at byte clock rise");

	////////////////////////////////////////////////////////////////////
	// add bus domain: pin latched on the falling edge
	always_comb begin
		add_next       = add_reg;
		add_next.rst_s = {add_reg.rst_s[0], i_rst_n};
		add_next.en_s  = {add_reg.en_s[0], core_reg.cfg_add};
		if (!add_reg.rst_s[1]) begin
			add_next.bit6 = 1'b0;
			add_next.tog  = 1'b0;
		end else if (add_reg.en_s[1]) begin
			add_next.bit6 = i_shared_bit6;
			add_next.tog  = !add_reg.tog;
		end
	end

	always_ff @(negedge i_add_bus_clock) begin
		add_reg <= add_next;
	end

	a_add_latch: assert property (@(negedge i_add_bus_clock)
		disable iff (!add_reg.rst_s[1])
		add_reg.en_s[1] |=> (add_reg.bit6 == $past(i_shared_bit6)) &&
		(add_reg.tog != $past(add_reg.tog)))
		else $error("add bus bit not latched on falling edge");

	////////////////////////////////////////////////////////////////////
	// payload domain: serial bit, frame count, skip indicator
	always_comb begin
		pay_next       = pay_reg;
		pay_next.rst_s = {pay_reg.rst_s[0], i_rst_n};
		pay_next.on_s  = {pay_reg.on_s[0], core_reg.cfg_clr};
		if (!pay_reg.rst_s[1]) begin
			pay_next.bit6 = 1'b0;
			pay_next.tog  = 1'b0;
			pay_next.cnt  = '0;
			pay_next.fend = 1'b0;
			pay_next.ohi  = 1'b0;
		end else if (pay_reg.on_s[1]) begin
			// cnt is the index of the bit taken at the next edge
			if (pay_reg.cnt == LAST_BIT) begin
				pay_next.cnt = '0;
			end else begin
				pay_next.cnt = pay_reg.cnt + 1'b1;
			end
			// a bit after a skip flag is dropped, as the far end sent none
			if (!pay_reg.ohi) begin
				pay_next.bit6 = i_shared_bit6;
				pay_next.tog  = !pay_reg.tog;
			end
			pay_next.ohi  = i_overhead_slot;
			pay_next.fend = (pay_next.cnt == LAST_BIT);
		end else begin
			pay_next.cnt  = '0;
			pay_next.fend = 1'b0;
			pay_next.ohi  = 1'b0;
		end
	end

	always_ff @(posedge i_payload_input_clock) begin
		pay_reg <= pay_next;
	end

	a_pay_sample: assert property (@(posedge i_payload_input_clock)
		disable iff (!pay_reg.rst_s[1])
		pay_reg.on_s[1] && !pay_reg.ohi |=>
		(pay_reg.bit6 == $past(i_shared_bit6)) &&
		(pay_reg.tog != $past(pay_reg.tog)))
		else $error("payload bit not sampled on clock rise");
	a_fend_last: assert property (@(posedge i_payload_input_clock)
		disable iff (!pay_reg.rst_s[1])
		o_frame_end_pulse |-> (pay_reg.cnt == LAST_BIT))
		else $error("frame end pulse not on last bit");
	a_fend_single: assert property (@(posedge i_payload_input_clock)
		disable iff (!pay_reg.rst_s[1])
		o_frame_end_pulse |=> !o_frame_end_pulse)
		else $error("frame end pulse longer than one period");

	////////////////////////////////////////////////////////////////////
	// capture buffer and outputs
	bit6_fifo #(
		.W     (SAMPLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_valid (core_reg.push),
		.o_ready (f_ready),
		.i_data  (core_reg.smp),
		.o_valid (o_sample_valid),
		.i_ready (i_sample_ready),
		.o_data  (o_sample)
	);

	assign o_hdlc_tx_byte_clock      = core_reg.hclk;
	assign o_overflow                = core_reg.ovf;
	assign o_frame_end_pulse         = pay_reg.fend;
	assign o_overhead_skip_indicator = pay_reg.ohi;
endmodule

// ===== design/bit6_mux_pkg.sv
// shared constants and types for the channel 0 input bit 6 multiplexer
package bit6_mux_pkg;

	// hdlc byte clock half period, in system clock cycles
	localparam int HDLC_HALF_DEF = 4;
	localparam int DIV_W         = 8;
	// bits per serial payload frame (plain default, set per stream type)
	localparam int FRAME_BITS_DEF = 1024;
	localparam int CNT_W          = 16;
	// words of capture buffering toward the consumer
	localparam int FIFO_DEPTH_DEF = 32;

	// operating mode when the add bus is off
	typedef enum logic [1:0] {
		MODE_IDLE  = 2'b00,
		MODE_HDLC  = 2'b01,
		MODE_CLEAR = 2'b10
	} mode_type;

	// role under which a captured bit was taken
	typedef enum logic [1:0] {
		ROLE_ADD     = 2'b00,
		ROLE_HDLC    = 2'b01,
		ROLE_PAYLOAD = 2'b10
	} role_type;

	typedef struct packed {
		role_type role;
		logic     bit6;
	} sample_type;

	localparam int SAMPLE_W = $bits(sample_type);

	// system clock domain state
	typedef struct packed {
		logic             cfg_add;
		logic             cfg_clr;
		logic [DIV_W-1:0] div;
		logic             hclk;
		logic [2:0]       add_t;
		logic [2:0]       pay_t;
		logic [1:0]       pin_s;
		logic             push;
		sample_type       smp;
		logic             ovf;
	} core_type;

	// add bus clock domain state
	typedef struct packed {
		logic [1:0] rst_s;
		logic [1:0] en_s;
		logic       bit6;
		logic       tog;
	} add_type;

	// payload input clock domain state
	typedef struct packed {
		logic [1:0]       rst_s;
		logic [1:0]       on_s;
		logic             bit6;
		logic             tog;
		logic [CNT_W-1:0] cnt;
		logic             fend;
		logic             ohi;
	} pay_type;

endpackage

// ===== test/bit6_mux_tb.sv
// self-checking bench for the shared bit 6 multiplexer
`timescale 1ns/1ps

module bit6_mux_tb;
	import bit6_mux_pkg::*;
	localparam logic [CNT_W-1:0] FB = CNT_W'(8);
	logic       i_clk, i_rst_n, add_en, add_clk, tb_bit, use_model;
	logic       run, send, rdy, hclk, ohi, fend, sv, ovf, pclk, mbit, slot;
	logic [15:0] m_pat;
	mode_type   mode;
	sample_type smp;
	int         m_edges, m_fends, n_fail, comparisons, n_ovf;
	logic [2:0] exp_q[$];
	wire        pin = use_model ? mbit : tb_bit;

	bit6_mux #(.FRAME_BITS(FB)) u_dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_add_bus_enable(add_en),
		.i_mode(mode), .i_add_bus_clock(add_clk),
		.i_payload_input_clock(pclk), .i_shared_bit6(pin),
		.i_overhead_slot(slot), .o_hdlc_tx_byte_clock(hclk),
		.o_overhead_skip_indicator(ohi), .o_frame_end_pulse(fend),
		.o_sample(smp), .o_sample_valid(sv), .i_sample_ready(rdy),
		.o_overflow(ovf));
	far_end_model u_far (
		.i_run(run), .i_send(send), .i_pattern(m_pat), .i_skip_ind(ohi),
		.i_fend(fend), .o_clk(pclk), .o_bit(mbit), .o_slot(slot),
		.o_edges(m_edges), .o_fends(m_fends));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// expected hdlc bits queue up at each byte clock rise
	always @(posedge hclk) begin
		if (mode == MODE_HDLC && !add_en) exp_q.push_back({ROLE_HDLC, pin});
	end
	always @(posedge i_clk) if (ovf === 1'b1) n_ovf++;

	////////////////////////////////////////////////////////////////////
	task automatic step(int n = 1);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic pop(logic [2:0] exp);
		int k;
		for (k = 0; k < 400 && sv !== 1'b1; k++) step();
		if (k == 400) n_fail++;
		if (k == 400) tally_and_finish();
		check("sample", smp, exp);
		rdy = 1'b1;
		step();
		rdy = 1'b0;
		step();
	endtask
	// empty the buffer of warm-up captures
	task automatic drain();
		rdy = 1'b1;
		step(40);
		rdy = 1'b0;
		step();
	endtask
	// wait out one byte clock level; a stuck clock ends the run
	task automatic hold_while_hclk(logic lvl, output int n);
		for (n = 0; n < 40 && hclk === lvl; n++) step();
		if (n == 40) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	// data changes with the rise, is latched at the fall
	task automatic add_fall(logic b);
		tb_bit = b;
		add_clk = 1'b1;
		step(4);
		add_clk = 1'b0;
		step(4);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic test_add();
		logic [7:0] pat = 8'hB4;
		add_en = 1'b1;
		mode = MODE_HDLC;
		repeat (3) add_fall(1'b0);
		drain();
		check("byte clock off", hclk, 0);
		for (int i = 0; i < 8; i++) add_fall(pat[i]);
		for (int i = 0; i < 8; i++) pop({ROLE_ADD, pat[i]});
		check("add empty", sv, 0);
		add_en = 1'b0;
		mode = MODE_IDLE;
		$display("test add done");
	endtask
	// byte clock shape, capture at its rise, fill past full, drain
	task automatic test_hdlc();
		int k;
		int hi;
		int lo;
		n_ovf = 0;
		mode = MODE_HDLC;
		hold_while_hclk(1'b0, k);
		hold_while_hclk(1'b1, hi);
		hold_while_hclk(1'b0, lo);
		check("byte clock high", hi, HDLC_HALF_DEF);
		check("byte clock low", lo, HDLC_HALF_DEF);
		for (k = 0; k < 38; k++) begin
			hold_while_hclk(1'b1, hi);
			tb_bit = k[0] ^ k[2];
			hold_while_hclk(1'b0, lo);
		end
		step(HDLC_HALF_DEF);
		mode = MODE_IDLE;
		check("queued", exp_q.size(), 40);
		check("overflows", n_ovf, 8);
		for (k = 0; k < 32; k++) pop(exp_q[k]);
		repeat (8) begin
			tb_bit = ~tb_bit;
			step(3);
		end
		check("idle empty", sv, 0);
		check("idle byte clock", hclk, 0);
		$display("test hdlc done");
	endtask
	task automatic test_payload();
		int k;
		mode = MODE_CLEAR;
		use_model = 1'b1;
		run = 1'b1;
		step(150);
		run = 1'b0;
		step(60);
		drain();
		m_pat = 16'h6D3A;
		send = 1'b1;
		for (k = 0; k < 900 && !(m_edges == 16 && pclk == 1'b0); k++) step();
		if (k == 900) begin
			n_fail++;
			tally_and_finish();
		end
		step(30);
		for (k = 0; k < 15; k++) pop({ROLE_PAYLOAD, m_pat[k]});
		check("payload empty", sv, 0);
		check("frame ends", m_fends, 2);
		send = 1'b0;
		use_model = 1'b0;
		mode = MODE_IDLE;
		$display("test payload done");
	endtask

	// link clocks run during reset so their domains see it too
	initial begin
		{i_rst_n, add_en, add_clk, tb_bit, use_model, send, rdy} = '0;
		run = 1'b1;
		mode = MODE_IDLE;
		m_pat = '0;
		n_fail = 0;
		comparisons = 0;
		repeat (12) add_fall(1'b0);
		i_rst_n = 1'b1;
		run = 1'b0;
		step();
		check("reset valid", sv, 0);
		check("reset overflow", ovf, 0);
		test_add();
		test_hdlc();
		test_payload();
		tally_and_finish();
	end
	// a hang counts as a mismatch
	initial begin
		#50000;
		n_fail++;
		tally_and_finish();
	end
endmodule

// ===== test/far_end_model.sv
// far end model: system side equipment sending serial payload bits
`timescale 1ns/1ps

module far_end_model #(
	parameter int SKIP_AT = 5
) (
	input  wire logic        i_run,      // clock only, no data
	input  wire logic        i_send,     // one burst of 16 edges
	input  wire logic [15:0] i_pattern,  // burst bits, lsb first
	input  wire logic        i_skip_ind, // overhead skip indicator
	input  wire logic        i_fend,     // frame end pulse
	output logic             o_clk,      // payload input clock
	output logic             o_bit,      // serial payload bit
	output logic             o_slot,     // overhead slot request
	output int               o_edges,    // edges in this burst
	output int               o_fends     // frame end periods seen
);
	int idx;
	wire go = (i_run || i_send) && !(i_send && o_edges >= 16);

	////////////////////////////////////////////////////////////////////
	// clock stands low between bursts; the odd offset keeps it
	// clear of the system clock edges, 1.3 ns after one
	initial begin
		o_clk = 1'b0;
		o_bit = 1'b0;
		o_slot = 1'b0;
		o_edges = 0;
		o_fends = 0;
		#1.3;
		forever begin
			#62.5;
			if (go || o_clk) o_clk = ~o_clk;
		end
	end
	// first bit is up before the first edge of a burst
	always @(posedge i_send) begin
		idx = 1;
		o_edges = 0;
		o_fends = 0;
		o_bit = i_pattern[0];
	end
	// count edges and frame end periods; ask for one overhead slot
	always @(posedge o_clk) begin
		if (i_send) o_edges = o_edges + 1;
		if (i_send && i_fend === 1'b1) o_fends = o_fends + 1;
		o_slot <= i_send && o_edges == SKIP_AT;
	end
	// next bit on the fall; after a skip the bit is withheld
	always @(negedge o_clk) begin
		if (!i_send) o_bit = 1'b0;
		else if (i_skip_ind === 1'b1) o_bit = ~o_bit;
		else begin
			o_bit = i_pattern[idx[3:0]];
			idx = idx + 1;
		end
	end
endmodule
